// ===== rtl/phase_offset_gen.sv
`timescale 1ns/1ns
module phase_offset_gen
  import pmic_regs_pkg::*;
#(
  parameter int PERIOD = DEFAULT_SWITCH_PERIOD
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic srst_in,
  // quarter-cycle delay codes
  input wire logic [1:0] buck2_code_in,
  input wire logic [1:0] buck3_code_in,
  // one-cycle switching-cycle start pulses
  output logic buck1_start_out,
  output logic buck2_start_out,
  output logic buck3_start_out
);
  localparam int CW = $clog2(PERIOD);
  localparam int QUARTER = PERIOD / PHASE_STEPS;
  logic [CW-1:0] count_ff;

  function automatic logic [CW-1:0] offset(input logic [1:0] code);
    offset = CW'(int'(code) * QUARTER);
  endfunction

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      count_ff <= '0;
    end else if (count_ff == CW'(PERIOD - 1)) begin
      count_ff <= '0;
    end else begin
      count_ff <= count_ff + 1'b1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      buck1_start_out <= 1'b0;
      buck2_start_out <= 1'b0;
      buck3_start_out <= 1'b0;
    end else begin
      buck1_start_out <= (count_ff == '0);
      buck2_start_out <= (count_ff == offset(buck2_code_in));
      buck3_start_out <= (count_ff == offset(buck3_code_in));
    end
  end
endmodule // phase_offset_gen

// ===== rtl/pmic_reg_bank.sv
`timescale 1ns/1ns
module pmic_reg_bank
  import pmic_regs_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = DEFAULT_SLAVE_ADDR,
  parameter logic [7:0] REVISION = DEFAULT_REVISION,
  parameter int SWITCH_PERIOD = DEFAULT_SWITCH_PERIOD
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic srst_in,
  // two-wire serial bus; sda is open drain, oe low pulls the line low
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n_out,
  // comparator and monitor inputs
  input wire logic undervoltage_lockout_in,
  input wire logic power_fail_sense_in,
  input wire logic battery_sense_in,
  input wire logic [SUPPLY_COUNT-1:0] supply_low_in,
  input wire logic dynamic_voltage_move_in,
  // enable pins
  input wire logic buck1_enable_pin_in,
  input wire logic buck2_enable_pin_in,
  input wire logic buck3_enable_pin_in,
  input wire logic linear_reg_enable_pin_in,
  // supply and converter controls
  output logic [SUPPLY_COUNT-1:0] supply_on_out,
  output logic forced_fixed_freq_bit_buck1_out,
  output logic forced_fixed_freq_bit_buck2_out,
  output logic forced_fixed_freq_bit_buck3_out,
  output logic low_ripple_out,
  output logic buck1_start_out,
  output logic buck2_start_out,
  output logic buck3_start_out,
  // fault interrupt, active low
  output logic fault_int_n_out
);
  localparam int NSYNC = 10 + SUPPLY_COUNT;

  typedef enum {
    ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_PTR, ST_ACK_PTR,
    ST_WDATA, ST_ACK_W, ST_RDATA, ST_RACK
  } bus_state_t;

  // synchronised pins
  logic [NSYNC-1:0] pins_sync;
  logic scl_s, sda_s, undervoltage_lockout_s, pfail_s, lbatt_s, dvm_s;
  logic [SUPPLY_COUNT-1:0] low_s;
  logic [SUPPLY_COUNT-1:0] pin_en_s;

  // scl and sda idle high; a low reset value would fake a bus edge after reset
  sync_two_ff #(
    .WIDTH(NSYNC),
    .RESET_VALUE({2'b11, {(NSYNC - 2){1'b0}}})
  ) u_sync (
    .clock_in(clock_in),
    .srst_in(srst_in),
    .async_in({scl_in, sda_in, undervoltage_lockout_in, power_fail_sense_in,
               battery_sense_in, dynamic_voltage_move_in, supply_low_in,
               buck1_enable_pin_in, buck2_enable_pin_in, buck3_enable_pin_in,
               linear_reg_enable_pin_in}),
    .sync_out(pins_sync)
  );

  logic buck1_pin_s, buck2_pin_s, buck3_pin_s, lreg_pin_s;
  assign {scl_s, sda_s, undervoltage_lockout_s, pfail_s, lbatt_s, dvm_s, low_s,
          buck1_pin_s, buck2_pin_s, buck3_pin_s, lreg_pin_s} = pins_sync;
  // the shared linear regulator pin gates both linear regulators
  assign pin_en_s = {buck1_pin_s, buck2_pin_s, buck3_pin_s, lreg_pin_s, lreg_pin_s};

  // registers
  logic [7:0] mask_ff;
  logic [7:0] enable_ff;
  conv_ctrl_t conv_ff;
  logic [7:0] blocked_ff;
  reg_write_t wr_req_ff;
  logic status_read_ff;

  // status composition
  logic [SUPPLY_COUNT-1:0] supply_on;
  logic [SUPPLY_COUNT-1:0] supply_fault;
  logic [7:0] status;

  // the register bit and the pin must both be high
  assign supply_on = enable_ff[SUPPLY_LSB +: SUPPLY_COUNT] & pin_en_s;

  always_comb begin
    supply_fault = low_s & supply_on;
    supply_fault[BUCK3_IDX] = supply_fault[BUCK3_IDX] & ~dvm_s;
    status = '0;
    status[STAT_POWER_FAIL_BIT] = pfail_s;
    status[STAT_LOW_BATT_BIT] = lbatt_s;
    status[SUPPLY_LSB +: SUPPLY_COUNT] = supply_fault;
  end

  function automatic logic [7:0] reg_read(input logic [7:0] addr, input logic [7:0] stat,
                                           input logic [7:0] msk, input logic [7:0] ena,
                                           input conv_ctrl_t cc);
    case (addr)
      ADDR_REVISION: reg_read = REVISION;
      ADDR_STATUS: reg_read = stat;
      ADDR_MASK: reg_read = msk;
      ADDR_ENABLE: reg_read = ena;
      ADDR_CONV_CTRL: reg_read = cc;
      default: reg_read = UNMAPPED_READ;
    endcase
  endfunction

  // write strobe decode shared by the three writable registers
  function automatic logic wr_hit(input reg_write_t req, input logic [7:0] addr);
    wr_hit = req.valid && (req.addr == addr);
  endfunction

  // mask register; undervoltage lockout reloads the default
  always_ff @(posedge clock_in) begin
    if (srst_in || undervoltage_lockout_s) begin
      mask_ff <= MASK_RESET;
    end else if (wr_hit(wr_req_ff, ADDR_MASK)) begin
      mask_ff <= wr_req_ff.data & MASK_RW_BITS;
    end
  end

  // supply enable register; a low pin wins over a host write to the same bit
  always_ff @(posedge clock_in) begin
    if (srst_in || undervoltage_lockout_s) begin
      enable_ff <= ENABLE_RESET;
    end else begin
      if (wr_hit(wr_req_ff, ADDR_ENABLE)) begin
        enable_ff <= (wr_req_ff.data & ENABLE_RW_BITS) | ~ENABLE_RW_BITS;
      end
      for (int i = 0; i < SUPPLY_COUNT; i++) begin
        if (!pin_en_s[i]) begin
          enable_ff[SUPPLY_LSB + i] <= 1'b1;
        end
      end
    end
  end

  // converter control; every bit is writable
  always_ff @(posedge clock_in) begin
    if (srst_in || undervoltage_lockout_s) begin
      conv_ff <= CONV_CTRL_RESET;
    end else if (wr_hit(wr_req_ff, ADDR_CONV_CTRL)) begin
      conv_ff <= wr_req_ff.data;
    end
  end

  // interrupt blocking: a read blocks the bits active at that moment; a block
  // lifts when its bit goes inactive, so a later fault can interrupt again
  always_ff @(posedge clock_in) begin
    if (srst_in || undervoltage_lockout_s) begin
      blocked_ff <= '0;
    end else if (status_read_ff) begin
      blocked_ff <= (blocked_ff | status) & status;
    end else begin
      blocked_ff <= blocked_ff & status;
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      fault_int_n_out <= 1'b1;
    end else begin
      fault_int_n_out <= ~|(status & ~mask_ff & ~blocked_ff);
    end
  end

  // supply switches
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      supply_on_out <= '0;
    end else begin
      supply_on_out <= supply_on;
    end
  end

  // converter controls
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      forced_fixed_freq_bit_buck1_out <= 1'b0;
      forced_fixed_freq_bit_buck2_out <= 1'b0;
      forced_fixed_freq_bit_buck3_out <= 1'b0;
      low_ripple_out <= 1'b0;
    end else begin
      forced_fixed_freq_bit_buck2_out <= conv_ff.forced_fixed_freq_bit_buck2;
      forced_fixed_freq_bit_buck1_out <= conv_ff.forced_fixed_freq_bit_buck1;
      forced_fixed_freq_bit_buck3_out <= conv_ff.forced_fixed_freq_bit_buck3;
      low_ripple_out <= conv_ff.low_ripple;
    end
  end

  phase_offset_gen #(
    .PERIOD(SWITCH_PERIOD)
  ) u_phase (
    .clock_in(clock_in),
    .srst_in(srst_in),
    .buck2_code_in(conv_ff.buck2_phase),
    .buck3_code_in(conv_ff.buck3_phase),
    .buck1_start_out(buck1_start_out),
    .buck2_start_out(buck2_start_out),
    .buck3_start_out(buck3_start_out)
  );

  // serial slave engine
  bus_state_t state_ff;
  logic scl_q_ff, sda_q_ff;
  logic [3:0] bit_cnt_ff;
  logic [7:0] shift_ff;
  logic [7:0] ptr_ff;
  logic [7:0] rd_ff;
  logic rw_ff;
  logic master_ack_ff;
  logic scl_rise, scl_fall, start_cond, stop_cond;
  logic [7:0] rd_value;
  logic read_load, data_byte_end;

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
    end else begin
      scl_q_ff <= scl_s;
      sda_q_ff <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_q_ff;
  assign scl_fall = ~scl_s & scl_q_ff;
  assign start_cond = scl_s & scl_q_ff & sda_q_ff & ~sda_s;
  assign stop_cond = scl_s & scl_q_ff & ~sda_q_ff & sda_s;

  // a byte is loaded for the host after an address ack with read set, or a host ack
  assign rd_value = reg_read(ptr_ff, status, mask_ff, enable_ff, conv_ff);
  assign read_load = scl_fall && ((state_ff == ST_ACK_ADDR && rw_ff) ||
                                  (state_ff == ST_RACK && master_ack_ff));
  assign data_byte_end = scl_fall && state_ff == ST_WDATA && bit_cnt_ff == 4'h8;

  // one-cycle strobes towards the registers; addr and data only count with valid
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      wr_req_ff <= '0;
      status_read_ff <= 1'b0;
    end else begin
      wr_req_ff.valid <= data_byte_end;
      wr_req_ff.addr <= ptr_ff;
      wr_req_ff.data <= shift_ff;
      status_read_ff <= read_load && (ptr_ff == ADDR_STATUS);
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      state_ff <= ST_IDLE;
      bit_cnt_ff <= '0;
      shift_ff <= '0;
      ptr_ff <= '0;
      rd_ff <= '0;
      rw_ff <= 1'b0;
      master_ack_ff <= 1'b0;
      sda_oe_n_out <= 1'b1;
    end else begin
      if (start_cond) begin
        state_ff <= ST_ADDR;
        bit_cnt_ff <= '0;
        sda_oe_n_out <= 1'b1;
      end else if (stop_cond) begin
        state_ff <= ST_IDLE;
        sda_oe_n_out <= 1'b1;
      end else if (scl_rise) begin
        case (state_ff)
          ST_ADDR, ST_PTR, ST_WDATA: begin
            shift_ff <= {shift_ff[6:0], sda_s};
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
          end
          ST_RDATA: bit_cnt_ff <= bit_cnt_ff + 4'h1;
          ST_RACK: master_ack_ff <= ~sda_s;
          default: ;
        endcase
      end else if (scl_fall) begin
        case (state_ff)
          ST_ADDR: begin
            if (bit_cnt_ff == 4'h8) begin
              if (shift_ff[7:1] == SLAVE_ADDR) begin
                sda_oe_n_out <= 1'b0;
                rw_ff <= shift_ff[0];
                state_ff <= ST_ACK_ADDR;
              end else begin
                state_ff <= ST_IDLE;
              end
            end
          end
          ST_ACK_ADDR, ST_RACK: begin
            bit_cnt_ff <= '0;
            if (read_load) begin
              // first bit goes out now; the pointer steps for burst reads
              rd_ff <= {rd_value[6:0], 1'b0};
              sda_oe_n_out <= rd_value[7];
              ptr_ff <= ptr_ff + 8'h01;
              state_ff <= ST_RDATA;
            end else if (state_ff == ST_ACK_ADDR) begin
              sda_oe_n_out <= 1'b1;
              state_ff <= ST_PTR;
            end else begin
              sda_oe_n_out <= 1'b1;
              state_ff <= ST_IDLE;
            end
          end
          ST_PTR, ST_WDATA: begin
            if (bit_cnt_ff == 4'h8) begin
              sda_oe_n_out <= 1'b0;
              if (state_ff == ST_PTR) begin
                ptr_ff <= shift_ff;
                state_ff <= ST_ACK_PTR;
              end else begin
                ptr_ff <= ptr_ff + 8'h01;
                state_ff <= ST_ACK_W;
              end
            end
          end
          ST_ACK_PTR, ST_ACK_W: begin
            sda_oe_n_out <= 1'b1;
            bit_cnt_ff <= '0;
            state_ff <= ST_WDATA;
          end
          ST_RDATA: begin
            if (bit_cnt_ff == 4'h8) begin
              sda_oe_n_out <= 1'b1;
              state_ff <= ST_RACK;
            end else begin
              sda_oe_n_out <= rd_ff[7];
              rd_ff <= {rd_ff[6:0], 1'b0};
            end
          end
          default: state_ff <= ST_IDLE;
        endcase
      end
    end
  end

  // the line is only ever pulled low; the enable carries the data
  always_ff @(posedge clock_in) begin
    sda_out <= 1'b0;
  end
endmodule // pmic_reg_bank

// ===== rtl/pmic_regs_pkg.sv
package pmic_regs_pkg;

  localparam logic [7:0] ADDR_REVISION = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h01;
  localparam logic [7:0] ADDR_MASK = 8'h02;
  localparam logic [7:0] ADDR_ENABLE = 8'h03;
  localparam logic [7:0] ADDR_CONV_CTRL = 8'h04;

  localparam logic [7:0] MASK_RESET = 8'hc0;
  localparam logic [7:0] ENABLE_RESET = 8'hff;
  localparam logic [7:0] CONV_CTRL_RESET = 8'hb1;
  localparam logic [7:0] UNMAPPED_READ = 8'hff;

  // writable bit sets; the rest of each register is constant
  localparam logic [7:0] MASK_RW_BITS = 8'hfe;
  localparam logic [7:0] ENABLE_RW_BITS = 8'h3e;

  localparam int STAT_POWER_FAIL_BIT = 7;
  localparam int STAT_LOW_BATT_BIT = 6;
  // supply index 4..0 = buck1, buck2, buck3, linear_reg2, linear_reg1 at bits 5..1
  localparam int SUPPLY_LSB = 1;
  localparam int SUPPLY_COUNT = 5;
  localparam int BUCK3_IDX = 2;

  localparam logic [6:0] DEFAULT_SLAVE_ADDR = 7'h48;
  // arbitrary neutral revision code
  localparam logic [7:0] DEFAULT_REVISION = 8'h5a;

  localparam int PHASE_STEPS = 4;
  localparam int DEFAULT_SWITCH_PERIOD = 16;

  typedef struct packed {
    logic [1:0] buck2_phase;
    logic [1:0] buck3_phase;
    logic low_ripple;
    logic forced_fixed_freq_bit_buck2;
    logic forced_fixed_freq_bit_buck1;
    logic forced_fixed_freq_bit_buck3;
  } conv_ctrl_t;

  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_write_t;

endpackage

// ===== rtl/sync_two_ff.sv
`timescale 1ns/1ns
module sync_two_ff #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic srst_in,
  // async levels in, synchronised levels out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_ff;

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      meta_ff <= RESET_VALUE;
      sync_out <= RESET_VALUE;
    end else begin
      meta_ff <= async_in;
      sync_out <= meta_ff;
    end
  end
endmodule // sync_two_ff

// ===== verif/i2c_host_model.sv
`timescale 1ns/1ns
module i2c_host_model
  import pmic_regs_pkg::*;
(
  // clock
  input wire logic clock_in,
  // serial bus; a released data line reads high through the pull-up
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_oe_n_out
);
  logic ph = 1'b0;
  initial begin
    scl_out = 1'b1;
    sda_oe_n_out = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
  endtask
  // low half alternates 6 and 7 clocks so scl averages 125 ns
  task automatic bit_io(input logic b, output logic s);
    tick(3 + ph);
    ph = ~ph;
    sda_oe_n_out <= b;
    tick(3);
    scl_out <= 1'b1;
    tick(5);
    s = sda_in;
    tick(1);
    scl_out <= 1'b0;
  endtask
  // waits long enough for the slave to drop a pending ack before scl rises
  task automatic start();
    tick(4);
    sda_oe_n_out <= 1'b1;
    tick(3);
    scl_out <= 1'b1;
    tick(6);
    sda_oe_n_out <= 1'b0;
    tick(6);
    scl_out <= 1'b0;
  endtask
  task automatic stop();
    tick(3);
    sda_oe_n_out <= 1'b0;
    tick(3);
    scl_out <= 1'b1;
    tick(6);
    sda_oe_n_out <= 1'b1;
    tick(6);
  endtask
  task automatic put(input logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
  endtask
  // ack high asks for another byte, ack low ends the read
  task automatic get(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(~ack, s);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    start();
    put({DEFAULT_SLAVE_ADDR, 1'b0});
    put(a);
    put(d);
    stop();
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    start();
    put({DEFAULT_SLAVE_ADDR, 1'b0});
    put(a);
    start();
    put({DEFAULT_SLAVE_ADDR, 1'b1});
    get(1'b0, d);
    stop();
  endtask
  task automatic rd2(input logic [7:0] a, output logic [7:0] d0, output logic [7:0] d1);
    start();
    put({DEFAULT_SLAVE_ADDR, 1'b0});
    put(a);
    start();
    put({DEFAULT_SLAVE_ADDR, 1'b1});
    get(1'b1, d0);
    get(1'b0, d1);
    stop();
  endtask
endmodule // i2c_host_model

// ===== verif/pmic_reg_bank_sva.sv
`timescale 1ns/1ns
module pmic_reg_bank_sva
  import pmic_regs_pkg::*;
#(
  parameter int SWITCH_PERIOD = DEFAULT_SWITCH_PERIOD
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic srst_in,
  // monitor and pin inputs
  input wire logic undervoltage_lockout_in,
  input wire logic power_fail_sense_in,
  input wire logic battery_sense_in,
  input wire logic [SUPPLY_COUNT-1:0] supply_low_in,
  input wire logic buck2_enable_pin_in,
  input wire logic buck3_enable_pin_in,
  input wire logic linear_reg_enable_pin_in,
  // design outputs
  input wire logic [SUPPLY_COUNT-1:0] supply_on_out,
  input wire logic forced_fixed_freq_bit_buck1_out,
  input wire logic forced_fixed_freq_bit_buck2_out,
  input wire logic forced_fixed_freq_bit_buck3_out,
  input wire logic low_ripple_out,
  input wire logic buck1_start_out,
  input wire logic fault_int_n_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (srst_in);
  // pins cross two sync flops and an output flop, so a few samples settle them
  a_pin_gates_supply: assert property (
    (!buck2_enable_pin_in)[*5] |-> !supply_on_out[3]) else $error("buck2 on, pin low");
  a_shared_linear_pin: assert property (
    (!linear_reg_enable_pin_in)[*5] |-> supply_on_out[1:0] == 2'b00)
    else $error("linear on, pin low");
  a_pin_restores_on: assert property (
    (!linear_reg_enable_pin_in)[*5] ##1 linear_reg_enable_pin_in[*6]
    |-> supply_on_out[1:0] == 2'b11) else $error("linear not back on");
  a_undervoltage_lockout_follow_pin: assert property (
    (undervoltage_lockout_in && buck3_enable_pin_in)[*8] |-> supply_on_out[2])
    else $error("buck3 off in lockout");
  a_undervoltage_lockout_conv_default: assert property (
    undervoltage_lockout_in[*8] |-> forced_fixed_freq_bit_buck3_out && !forced_fixed_freq_bit_buck1_out
    && !forced_fixed_freq_bit_buck2_out && !low_ripple_out) else $error("converter default wrong");
  a_undervoltage_lockout_supply_unmasked: assert property (
    (undervoltage_lockout_in && supply_low_in[0] && linear_reg_enable_pin_in)[*8]
    |-> !fault_int_n_out) else $error("supply fault masked in lockout");
  a_quiet_no_int: assert property (
    (!power_fail_sense_in && !battery_sense_in && supply_low_in == 5'h00)[*6]
    |-> fault_int_n_out) else $error("interrupt without fault");
  // the phase counter runs free through lockout, only reset restarts it
  a_buck1_period: assert property (
    buck1_start_out |-> ##SWITCH_PERIOD buck1_start_out) else $error("buck1 period");
endmodule // pmic_reg_bank_sva

bind pmic_reg_bank pmic_reg_bank_sva #(.SWITCH_PERIOD(SWITCH_PERIOD)) i_pmic_reg_bank_sva (
  .clock_in(clock_in), .srst_in(srst_in), .undervoltage_lockout_in(undervoltage_lockout_in),
  .power_fail_sense_in(power_fail_sense_in), .battery_sense_in(battery_sense_in),
  .supply_low_in(supply_low_in), .buck2_enable_pin_in(buck2_enable_pin_in),
  .buck3_enable_pin_in(buck3_enable_pin_in),
  .linear_reg_enable_pin_in(linear_reg_enable_pin_in), .supply_on_out(supply_on_out),
  .forced_fixed_freq_bit_buck1_out(forced_fixed_freq_bit_buck1_out), .forced_fixed_freq_bit_buck2_out(forced_fixed_freq_bit_buck2_out),
  .forced_fixed_freq_bit_buck3_out(forced_fixed_freq_bit_buck3_out), .low_ripple_out(low_ripple_out),
  .buck1_start_out(buck1_start_out), .fault_int_n_out(fault_int_n_out));

// ===== verif/pmic_reg_bank_test.sv
`timescale 1ns/1ns
module pmic_reg_bank_test;
  import pmic_regs_pkg::*;
  // arbitrary revision code
  localparam logic [7:0] REV = 8'h3c;
  localparam int PER = 16;
  logic clock_in = 1'b0;
  logic srst_in = 1'b1;
  logic undervoltage_lockout = 1'b0;
  logic pf = 1'b0;
  logic lb = 1'b0;
  logic dynamic_voltage_move = 1'b0;
  logic [4:0] low = 5'h00;
  logic [3:0] pins = 4'hf;
  logic [4:0] on;
  logic f1, f2, f3, rip, s1, s2, s3, int_n, scl, h_oe_n, d_oe_n;
  logic sda_o;
  logic [7:0] v, v2;
  int miscompares = 0;
  int n_tests = 0;
  wire sda = h_oe_n & (d_oe_n | sda_o);

  pmic_reg_bank #(.REVISION(REV), .SWITCH_PERIOD(PER)) i_pmic_reg_bank (
    .clock_in(clock_in), .srst_in(srst_in), .scl_in(scl), .sda_in(sda), .sda_out(sda_o),
    .sda_oe_n_out(d_oe_n), .undervoltage_lockout_in(undervoltage_lockout), .power_fail_sense_in(pf),
    .battery_sense_in(lb), .supply_low_in(low), .dynamic_voltage_move_in(dynamic_voltage_move),
    .buck1_enable_pin_in(pins[3]), .buck2_enable_pin_in(pins[2]),
    .buck3_enable_pin_in(pins[1]), .linear_reg_enable_pin_in(pins[0]),
    .supply_on_out(on), .forced_fixed_freq_bit_buck1_out(f1), .forced_fixed_freq_bit_buck2_out(f2), .forced_fixed_freq_bit_buck3_out(f3),
    .low_ripple_out(rip), .buck1_start_out(s1), .buck2_start_out(s2),
    .buck3_start_out(s3), .fault_int_n_out(int_n));
  i2c_host_model i_i2c_host_model (.clock_in(clock_in), .sda_in(sda), .scl_out(scl),
    .sda_oe_n_out(h_oe_n));

  task automatic report_and_stop();
    if (miscompares == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    i_i2c_host_model.rd(a, v);
    chk($sformatf("register %h", a), exp, v);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_i2c_host_model.wr(a, d);
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clock_in);
  endtask
  // offsets are counted from the buck1 pulse within one switching period
  task automatic phase(input logic [1:0] c2, input logic [1:0] c3);
    int n2 = -1;
    int n3 = -1;
    wr(ADDR_CONV_CTRL, {c2, c3, 4'h0});
    @(negedge clock_in);
    while (s1 !== 1'b1) @(negedge clock_in);
    for (int i = 0; i < PER; i++) begin
      if (s2 === 1'b1) n2 = i;
      if (s3 === 1'b1) n3 = i;
      @(negedge clock_in);
    end
    chk("buck2 delay", 8'(c2 * PER / 4), 8'(n2));
    chk("buck3 delay", 8'(c3 * PER / 4), 8'(n3));
    @(posedge clock_in);
  endtask

  initial begin
    forever #5 clock_in = ~clock_in;
  end
  // traffic needs about 15k cycles; six times that marks a hang
  initial begin
    #900000;
    miscompares++;
    report_and_stop();
  end
  initial begin
    wait_clk(20);
    srst_in <= 1'b0;
    wait_clk(5);
    rchk(ADDR_REVISION, REV);
    rchk(ADDR_MASK, MASK_RESET);
    rchk(ADDR_ENABLE, ENABLE_RESET);
    rchk(ADDR_CONV_CTRL, CONV_CTRL_RESET);
    wr(ADDR_REVISION, 8'h00);
    rchk(ADDR_REVISION, REV);
    rchk(8'h05, UNMAPPED_READ);
    wr(ADDR_MASK, 8'h55);
    rchk(ADDR_MASK, 8'h54);
    wr(ADDR_ENABLE, 8'h00);
    rchk(ADDR_ENABLE, 8'hc1);
    chk("supplies", 8'h00, {3'h0, on});
    wr(ADDR_ENABLE, 8'h28);
    rchk(ADDR_ENABLE, 8'he9);
    chk("supplies", 8'h14, {3'h0, on});
    pins <= 4'he;
    wait_clk(10);
    rchk(ADDR_ENABLE, 8'hef);
    pins <= 4'hf;
    wait_clk(10);
    chk("supplies", 8'h17, {3'h0, on});
    pins <= 4'hb;
    wait_clk(10);
    chk("supplies", 8'h17, {3'h0, on});
    rchk(ADDR_ENABLE, 8'hff);
    pins <= 4'hf;
    pf <= 1'b1;
    lb <= 1'b1;
    low <= 5'h15;
    wait_clk(10);
    chk("supplies", 8'h1f, {3'h0, on});
    rchk(ADDR_STATUS, 8'hea);
    dynamic_voltage_move <= 1'b1;
    wait_clk(10);
    rchk(ADDR_STATUS, 8'he2);
    wr(ADDR_ENABLE, 8'hdf);
    rchk(ADDR_STATUS, 8'hc2);
    chk("interrupt", 8'h01, {7'h0, int_n});
    low <= 5'h00;
    wait_clk(10);
    low <= 5'h01;
    wait_clk(10);
    chk("interrupt", 8'h00, {7'h0, int_n});
    wr(ADDR_MASK, 8'h02);
    chk("interrupt", 8'h01, {7'h0, int_n});
    wr(ADDR_CONV_CTRL, 8'h4e);
    rchk(ADDR_CONV_CTRL, 8'h4e);
    chk("converter mode", 8'h0e, {4'h0, rip, f2, f1, f3});
    for (int c = 0; c < 4; c++) phase(2'(c), 2'(3 - c));
    undervoltage_lockout <= 1'b1;
    wait_clk(12);
    undervoltage_lockout <= 1'b0;
    wait_clk(10);
    rchk(ADDR_MASK, MASK_RESET);
    rchk(ADDR_ENABLE, ENABLE_RESET);
    rchk(ADDR_CONV_CTRL, CONV_CTRL_RESET);
    chk("supplies", 8'h1f, {3'h0, on});
    // a host ack keeps the pointer stepping into the next register
    i_i2c_host_model.rd2(ADDR_MASK, v, v2);
    chk("burst first", MASK_RESET, v);
    chk("burst second", ENABLE_RESET, v2);
    report_and_stop();
  end
endmodule // pmic_reg_bank_test
